// ### dme_top.sv
// Data memory access control: internal RAM, control registers, data EEPROM
// with page buffer, and off-chip data path. Assumes a CPU core on CLK.
`include "dme_defines.svh"

module dme_top
#(
  parameter int PROG_CYCLES = `DME_PROG_CYCLES
)
(
  // Clock, reset, enable
  input  wire logic        CLK,
  input  wire logic        RST_B,
  input  wire logic        CE,
  // Internal data and register port
  input  wire logic [7:0]  D_ADDR,
  input  wire logic [7:0]  D_WDATA,
  input  wire logic        D_WR,
  input  wire logic        D_RD,
  input  wire logic        D_IND,
  output logic      [7:0]  D_RDATA,
  // External data move port
  input  wire logic [15:0] X_ADDR,
  input  wire logic        X_USE_PTR,
  input  wire logic [15:0] PTR0,
  input  wire logic [15:0] PTR1,
  input  wire logic [7:0]  X_WDATA,
  input  wire logic        X_WR,
  input  wire logic        X_RD,
  output logic      [7:0]  X_RDATA,
  output logic             X_RVALID,
  // Off-chip data memory pins
  output logic      [15:0] EXT_ADDR,
  output logic      [7:0]  EXT_WDATA,
  output logic             EXT_WR,
  output logic             EXT_RD,
  input  wire logic [7:0]  EXT_RDATA,
  // Supply monitor pin, low inhibits EEPROM writes
  input  wire logic        WR_ALLOW,
  // Status
  output logic             PTR_SEL,
  output logic             IRQ
);

  // Control and interrupt registers
  logic [3:0]  ctrl_reg, ctrl_next;
  logic [1:0]  ist_reg, ist_next;
  logic [1:0]  imk_reg, imk_next;
  logic        irq_reg, irq_next;
  // Programming engine
  dme_pkg::dme_prog_e st_reg, st_next;
  logic [31:0] cnt_reg, cnt_next;
  logic [5:0]  idx_reg, idx_next;
  logic        cpv_reg, cpv_next;
  logic [4:0]  cpi_reg, cpi_next;
  logic [31:0] mask_reg, mask_next;
  logic [5:0]  page_reg, page_next;
  dme_pkg::dme_byte_t last_reg, last_next;
  // Read answers
  logic        dsel_reg, dsel_next;
  dme_pkg::dme_byte_t sfr_reg, sfr_next;
  logic        xee_reg, xee_next;
  logic        xbusy_reg, xbusy_next;
  logic [2:0]  xpend_reg, xpend_next;
  dme_pkg::dme_byte_t xr_reg, xr_next;
  logic        xv_reg, xv_next;
  // Off-chip drive
  logic [15:0] ea_reg, ea_next;
  dme_pkg::dme_byte_t ew_reg, ew_next;
  logic        ewr_reg, ewr_next;
  logic        erd_reg, erd_next;
  // Synchronisers
  logic [7:0]  ext_s1, ext_s2;
  logic        inh_s1, inh_s2;

  // Memory ports
  logic [7:0]  ram_addr;
  logic        ram_we, ram_re;
  dme_pkg::dme_byte_t ram_q;
  logic [4:0]  buf_addr;
  logic        buf_we, buf_re;
  dme_pkg::dme_byte_t buf_q;
  logic [10:0] ee_addr;
  logic        ee_we, ee_re;
  dme_pkg::dme_byte_t ee_q;

  // Decoded requests
  logic        d_sfr;
  logic [15:0] x_addr;
  logic        x_ee;
  logic        busy;
  logic        ee_wr_try;
  logic        ee_wr_ok;
  logic [7:0]  ctrl_rd;

  function automatic logic is_ee(input logic sel, input logic [15:0] a);
    is_ee = sel && (a <= `DME_EE_TOP);
  endfunction

  assign busy = (st_reg != dme_pkg::DME_IDLE);

  // Pointer choice
  // pointer select
  assign x_addr = !X_USE_PTR ? X_ADDR : (ctrl_reg[`DME_BIT_PTR_SEL - 2] ? PTR1 : PTR0);

  assign x_ee = is_ee(ctrl_reg[`DME_BIT_EE_SEL - 2], x_addr);

  assign d_sfr = !D_IND && (D_ADDR >= `DME_SFR_BASE);

  assign ee_wr_try = CE && X_WR && x_ee;
  assign ee_wr_ok  = ee_wr_try && ctrl_reg[`DME_BIT_WR_EN - 2] && !busy && inh_s2;

  assign ctrl_rd = {2'b00, ctrl_reg, !busy, inh_s2};

  assign ram_addr = D_ADDR;
  assign ram_we   = CE && D_WR && !d_sfr;
  assign ram_re   = CE && D_RD && !d_sfr;

  assign buf_we   = ee_wr_ok;
  assign buf_re   = CE && (st_reg == dme_pkg::DME_COPY);
  assign buf_addr = buf_we ? x_addr[4:0] : idx_reg[4:0];

  assign ee_we   = CE && cpv_reg && mask_reg[cpi_reg];
  assign ee_re   = CE && X_RD && x_ee && !busy;
  assign ee_addr = ee_we ? {page_reg, cpi_reg} : x_addr[10:0];

  dme_mem #(.AW(8), .DW(8)) u_ram
  (
    .clk   (CLK),
    .ce    (CE),
    .addr  (ram_addr),
    .wdata (D_WDATA),
    .we    (ram_we),
    .re    (ram_re),
    .rdata (ram_q)
  );

  dme_mem #(.AW(5), .DW(8)) u_page
  (
    .clk   (CLK),
    .ce    (CE),
    .addr  (buf_addr),
    .wdata (X_WDATA),
    .we    (buf_we),
    .re    (buf_re),
    .rdata (buf_q)
  );

  dme_mem #(.AW(11), .DW(8)) u_eeprom
  (
    .clk   (CLK),
    .ce    (CE),
    .addr  (ee_addr),
    .wdata (buf_q),
    .we    (ee_we),
    .re    (ee_re),
    .rdata (ee_q)
  );

  // Register file and interrupts
  always_comb
  begin
    ctrl_next = ctrl_reg;
    ist_next  = ist_reg;
    imk_next  = imk_reg;
    sfr_next  = sfr_reg;
    dsel_next = dsel_reg;
    if (D_WR && d_sfr)
    begin
      unique case (D_ADDR)
        `DME_CTRL_ADDR:     ctrl_next = D_WDATA[5:2];
        `DME_IRQ_STAT_ADDR: ist_next  = ist_reg & ~D_WDATA[1:0];
        `DME_IRQ_MASK_ADDR: imk_next  = D_WDATA[1:0];
        default:            ;
      endcase
    end
    if (D_RD)
    begin
      dsel_next = d_sfr;
      unique case (D_ADDR)
        `DME_CTRL_ADDR:     sfr_next = ctrl_rd;
        `DME_IRQ_STAT_ADDR: sfr_next = {6'h00, ist_reg};
        `DME_IRQ_MASK_ADDR: sfr_next = {6'h00, imk_reg};
        default:            sfr_next = 8'h00;
      endcase
    end
    // Events win over a clear in the same cycle
    if (st_reg == dme_pkg::DME_WAIT && cnt_next == 32'd0)
    begin
      ist_next[`DME_IRQ_DONE] = 1'b1;
    end
    if (ee_wr_try && !ee_wr_ok)
    begin
      ist_next[`DME_IRQ_REFUSED] = 1'b1;
    end
    irq_next = |(ist_next & imk_next);
  end

  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      ctrl_reg <= `DME_CTRL_RST;
      ist_reg  <= `DME_IRQ_RST;
      imk_reg  <= `DME_IRQ_RST;
      irq_reg  <= 1'b0;
      sfr_reg  <= 8'h00;
      dsel_reg <= 1'b0;
    end
    else if (CE)
    begin
      ctrl_reg <= ctrl_next;
      ist_reg  <= ist_next;
      imk_reg  <= imk_next;
      irq_reg  <= irq_next;
      sfr_reg  <= sfr_next;
      dsel_reg <= dsel_next;
    end
  end

  // Programming engine: copy buffered page, then hold busy
  always_comb
  begin
    st_next   = st_reg;
    cnt_next  = cnt_reg;
    idx_next  = idx_reg;
    mask_next = mask_reg;
    page_next = page_reg;
    last_next = last_reg;
    cpv_next  = 1'b0;
    cpi_next  = idx_reg[4:0];
    unique case (st_reg)
      dme_pkg::DME_IDLE:
      begin
        if (ee_wr_ok)
        begin
          mask_next[x_addr[4:0]] = 1'b1;
          page_next = x_addr[10:5];
          last_next = X_WDATA;
          if (!ctrl_reg[`DME_BIT_LOAD_ONLY - 2])
          begin
            st_next  = dme_pkg::DME_COPY;
            idx_next = 6'd0;
            cnt_next = 32'(PROG_CYCLES);
          end
        end
      end
      dme_pkg::DME_COPY:
      begin
        cnt_next = cnt_reg - 32'd1;
        cpv_next = (idx_reg < `DME_PAGE_BYTES);
        idx_next = idx_reg + 6'd1;
        if (idx_reg == `DME_PAGE_BYTES)
        begin
          st_next = dme_pkg::DME_WAIT;
        end
      end
      dme_pkg::DME_WAIT:
      begin
        cnt_next = (cnt_reg == 32'd0) ? 32'd0 : cnt_reg - 32'd1;
        if (cnt_next == 32'd0)
        begin
          st_next   = dme_pkg::DME_IDLE;
          mask_next = 32'h0000_0000;
        end
      end
      default:
      begin
        st_next = dme_pkg::DME_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      st_reg   <= dme_pkg::DME_IDLE;
      cnt_reg  <= 32'h0000_0000;
      idx_reg  <= 6'h00;
      cpv_reg  <= 1'b0;
      cpi_reg  <= 5'h00;
      mask_reg <= 32'h0000_0000;
      page_reg <= 6'h00;
      last_reg <= 8'h00;
    end
    else if (CE)
    begin
      st_reg   <= st_next;
      cnt_reg  <= cnt_next;
      idx_reg  <= idx_next;
      cpv_reg  <= cpv_next;
      cpi_reg  <= cpi_next;
      mask_reg <= mask_next;
      page_reg <= page_next;
      last_reg <= last_next;
    end
  end

  // External data move answers and off-chip drive
  always_comb
  begin
    xee_next   = X_RD && x_ee;
    xbusy_next = busy;
    // Three stages: pin data needs two sync flops first
    xpend_next = {xpend_reg[1:0], X_RD && !x_ee};
    ea_next    = ea_reg;
    ew_next    = ew_reg;
    ewr_next   = X_WR && !x_ee;
    erd_next   = X_RD && !x_ee;
    if ((X_WR || X_RD) && !x_ee)
    begin
      ea_next = x_addr;
      ew_next = X_WDATA;
    end
    xv_next = xee_reg || xpend_reg[2];
    xr_next = xr_reg;
    if (xee_reg)
    begin
      xr_next = xbusy_reg ? (last_reg ^ `DME_MSB_FLIP) : ee_q;
    end
    else if (xpend_reg[2])
    begin
      xr_next = ext_s2;
    end
  end

  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      xee_reg   <= 1'b0;
      xbusy_reg <= 1'b0;
      xpend_reg <= 3'b000;
      xr_reg    <= 8'h00;
      xv_reg    <= 1'b0;
      ea_reg    <= 16'h0000;
      ew_reg    <= 8'h00;
      ewr_reg   <= 1'b0;
      erd_reg   <= 1'b0;
      ext_s1    <= 8'h00;
      ext_s2    <= 8'h00;
      inh_s1    <= 1'b0;
      inh_s2    <= 1'b0;
    end
    else if (CE)
    begin
      xee_reg   <= xee_next;
      xbusy_reg <= xbusy_next;
      xpend_reg <= xpend_next;
      xr_reg    <= xr_next;
      xv_reg    <= xv_next;
      ea_reg    <= ea_next;
      ew_reg    <= ew_next;
      ewr_reg   <= ewr_next;
      erd_reg   <= erd_next;
      ext_s1    <= EXT_RDATA;
      ext_s2    <= ext_s1;
      inh_s1    <= WR_ALLOW;
      inh_s2    <= inh_s1;
    end
  end

  // Internal read data from RAM register or register file
  assign D_RDATA   = dsel_reg ? sfr_reg : ram_q;
  assign X_RDATA   = xr_reg;
  assign X_RVALID  = xv_reg;
  assign EXT_ADDR  = ea_reg;
  assign EXT_WDATA = ew_reg;
  assign EXT_WR    = ewr_reg;
  assign EXT_RD    = erd_reg;
  assign PTR_SEL   = ctrl_reg[`DME_BIT_PTR_SEL - 2];
  assign IRQ       = irq_reg;

endmodule

// ### dme_defines.svh
// Offsets, field positions, reset values and timing of the data memory block.
// Assumes one 20 MHz clock; included by the top module and its checker.
`ifndef DME_DEFINES_SVH
`define DME_DEFINES_SVH

`define DME_SFR_BASE       8'h80
`define DME_CTRL_ADDR      8'h96
`define DME_IRQ_STAT_ADDR  8'h9C
`define DME_IRQ_MASK_ADDR  8'h9D

`define DME_EE_TOP         16'h07FF
`define DME_PAGE_BYTES     6'd32
`define DME_MSB_FLIP       8'h80

`define DME_BIT_LOAD_ONLY  5
`define DME_BIT_WR_EN      4
`define DME_BIT_EE_SEL     3
`define DME_BIT_PTR_SEL    2
`define DME_BIT_READY_BUSY    1
`define DME_BIT_WR_INH     0
`define DME_CTRL_RST       4'h0

`define DME_IRQ_DONE       0
`define DME_IRQ_REFUSED    1
`define DME_IRQ_RST        2'h0

`define DME_PROG_TIME_NS   4000000
`define DME_CLK_PERIOD_NS  50
`define DME_PROG_CYCLES    (`DME_PROG_TIME_NS / `DME_CLK_PERIOD_NS)

`endif

// ### dme_pkg.sv
// Types shared by the data memory block.
// Assumes nothing beyond the compile order.
package dme_pkg;

  typedef enum logic [1:0]
  {
    DME_IDLE = 2'b00,
    DME_COPY = 2'b01,
    DME_WAIT = 2'b11
  } dme_prog_e;

  typedef logic [7:0] dme_byte_t;

endpackage

// ### dme_mem.sv
// Single-port synchronous memory, registered read data.
// Assumes write and read never collide on the same cycle.
module dme_mem
#(
  parameter int AW = 8,
  parameter int DW = 8
)
(
  // Clock
  input  wire logic          clk,
  input  wire logic          ce,
  // Access
  input  wire logic [AW-1:0] addr,
  input  wire logic [DW-1:0] wdata,
  input  wire logic          we,
  input  wire logic          re,
  output logic      [DW-1:0] rdata
);

  logic [DW-1:0] mem [0:(1<<AW)-1];

  always_ff @(posedge clk)
  begin
    if (ce && we)
    begin
      mem[addr] <= wdata;
    end
    if (ce && re)
    begin
      rdata <= mem[addr];
    end
  end

endmodule

// ### dme_top_monitor.sv
// Concurrent checks on the ports of the data memory block.
// Assumes one clock, strobes only while CE high, bound to every dme_top.
`include "dme_defines.svh"

module dme_top_monitor
(
  // Clock and reset
  input wire logic        CLK,
  input wire logic        RST_B,
  input wire logic        CE,
  // Internal port
  input wire logic [7:0]  D_ADDR,
  input wire logic [7:0]  D_WDATA,
  input wire logic        D_WR,
  input wire logic        D_RD,
  input wire logic        D_IND,
  input wire logic [7:0]  D_RDATA,
  // External move port
  input wire logic [15:0] X_ADDR,
  input wire logic        X_USE_PTR,
  input wire logic [15:0] PTR0,
  input wire logic [15:0] PTR1,
  input wire logic [7:0]  X_WDATA,
  input wire logic        X_WR,
  input wire logic        X_RD,
  input wire logic        X_RVALID,
  // Off-chip pins and status
  input wire logic [15:0] EXT_ADDR,
  input wire logic [7:0]  EXT_WDATA,
  input wire logic        EXT_WR,
  input wire logic        EXT_RD,
  input wire logic        PTR_SEL
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_B);

  logic sel_reg;
  logic sel_next;
  logic ctrl_wr;
  logic ee_hit;

  // Shadow of the select bit from control writes
  always_comb
  begin
    ctrl_wr  = CE && D_WR && !D_IND && D_ADDR == `DME_CTRL_ADDR;
    ee_hit   = sel_reg && !X_USE_PTR && X_ADDR <= `DME_EE_TOP;
    sel_next = ctrl_wr ? D_WDATA[`DME_BIT_EE_SEL] : sel_reg;
  end

  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      sel_reg <= 1'b0;
    end
    else if (CE)
    begin
      sel_reg <= sel_next;
    end
  end

  sequence ee_answer;
    !EXT_RD ##1 X_RVALID;
  endsequence

  sequence ext_answer;
    EXT_RD ##3 X_RVALID;
  endsequence

  ee_read_route_a: assert property (X_RD && ee_hit |=> ee_answer)
    else $error("EEPROM read left the chip or came late");
  ee_write_local_a: assert property (X_WR && ee_hit |=> !EXT_WR)
    else $error("EEPROM write reached the off-chip pins");
  ext_read_route_a: assert property (X_RD && !sel_reg |=> ext_answer)
    else $error("Off-chip read not issued or answered late");
  ext_write_route_a: assert property (X_WR && !sel_reg |=> EXT_WR && EXT_WDATA == $past(X_WDATA))
    else $error("Off-chip write missing or wrong data");
  ptr_choice_a: assert property (X_RD && !sel_reg && X_USE_PTR
    |=> EXT_ADDR == ($past(PTR_SEL) ? $past(PTR1) : $past(PTR0)))
    else $error("Wrong data pointer used");
  ptr_sel_a: assert property (ctrl_wr |=> PTR_SEL == $past(D_WDATA[2]))
    else $error("Pointer select bit not stored");
  direct_sfr_a: assert property (D_RD && !D_IND && D_ADDR[7:5] == 3'b101
    |=> D_RDATA == 8'h00)
    else $error("Direct access above 7FH reached RAM");
  ctrl_top_bits_a: assert property (D_RD && !D_IND && D_ADDR == `DME_CTRL_ADDR
    |=> D_RDATA[7:6] == 2'b00)
    else $error("Control register upper bits not zero");
endmodule

bind dme_top dme_top_monitor u_mon (.*);

// ### dme_xmem.sv
// Off-chip data memory model on the external data pins.
// Assumes answers while the read pulse is high; else drives junk.
module dme_xmem
(
  // Clock
  input  wire logic       clk,
  // Access
  input  wire logic       rd,
  input  wire logic       wr,
  input  wire logic [7:0] addr,
  input  wire logic [7:0] wdata,
  output logic      [7:0] rdata
);
  logic [7:0] mem [256];
  logic [7:0] last;

  always_ff @(posedge clk)
  begin
    if (wr) mem[addr] <= wdata;
    if (rd) last <= mem[addr];
  end

  assign rdata = rd ? mem[addr] : ~last;
endmodule

// ### tb_dme_top.sv
// Self-checking bench of the data memory block.
// Assumes the monitor binds itself; off-chip memory model attached.
module tb_dme_top;
  timeunit 1ns;
  timeprecision 1ns;

  logic        CLK, RST_B, D_WR, D_RD, D_IND, X_USE_PTR, X_WR, X_RD, WR_ALLOW;
  logic [7:0]  D_ADDR, D_WDATA, X_WDATA, D_RDATA, X_RDATA, EXT_WDATA, EXT_RDATA;
  logic [15:0] X_ADDR, PTR0, PTR1, EXT_ADDR;
  logic        X_RVALID, EXT_WR, EXT_RD, PTR_SEL, IRQ;
  logic        CE;
  int          err_total, checked, i;
  int          cyc, t_wr;
  localparam int PROG = 40;
  logic [31:0] lf;
  logic [7:0]  b, d, q [32];

  dme_top #(.PROG_CYCLES(PROG)) uut (.*);
  dme_xmem mem (.clk(CLK), .rd(EXT_RD), .wr(EXT_WR), .addr(EXT_ADDR[7:0]),
    .wdata(EXT_WDATA), .rdata(EXT_RDATA));

  initial
  begin
    CLK = 1'b0;
    forever #25 CLK = ~CLK;
  end

  // Cycle count for timing the programming cycle
  always @(posedge CLK) cyc <= cyc + 1;

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic report_and_stop();
    $display("checked %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
    begin
      $display("TEST PASSED");
    end
    else
    begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    checked++;
    if (g !== e)
    begin
      err_total++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask

  task automatic dw(input logic [7:0] a, input logic [7:0] v, input logic ind);
    @(posedge CLK);
    D_WR <= 1'b1; D_ADDR <= a; D_WDATA <= v; D_IND <= ind;
    @(posedge CLK);
    D_WR <= 1'b0;
  endtask

  task automatic dr(input logic [7:0] a, input logic ind, output logic [7:0] v);
    @(posedge CLK);
    D_RD <= 1'b1; D_ADDR <= a; D_IND <= ind;
    @(posedge CLK);
    D_RD <= 1'b0;
    #1 v = D_RDATA;
  endtask

  task automatic xw(input logic [15:0] a, input logic [7:0] v);
    @(posedge CLK);
    X_WR <= 1'b1; X_ADDR <= a; X_WDATA <= v;
    @(posedge CLK);
    X_WR <= 1'b0;
    t_wr = cyc;
  endtask

  task automatic xr(input logic [15:0] a, output logic [7:0] v);
    int n;
    @(posedge CLK);
    X_RD <= 1'b1; X_ADDR <= a;
    @(posedge CLK);
    X_RD <= 1'b0;
    for (n = 0; n < 8; n++)
    begin
      @(posedge CLK);
      #1;
      if (X_RVALID === 1'b1) break;
    end
    if (n == 8)
    begin
      err_total++;
      report_and_stop();
    end
    v = X_RDATA;
  endtask

  task automatic wait_rdy();
    int n;
    for (n = 0; n < 60; n++)
    begin
      dr(8'h96, 1'b0, b);
      if (b[1] === 1'b1) break;
    end
    if (n == 60)
    begin
      err_total++;
      report_and_stop();
    end
    // Launch edge of the first ready poll, counted from the taken write
    chk(8'((cyc - 2 - t_wr) == PROG || (cyc - 2 - t_wr) == PROG + 1), 8'h01);
  endtask

  initial
  begin
    {D_WR, D_RD, D_IND, X_USE_PTR, X_WR, X_RD} = '0;
    {D_ADDR, D_WDATA, X_WDATA, X_ADDR, PTR0, PTR1} = '0;
    WR_ALLOW = 1'b1; RST_B = 1'b0; lf = 32'h0000_37ec;
    CE = 1'b1;
    cyc = 0;
    repeat (5) @(posedge CLK);
    RST_B <= 1'b1;
    repeat (3) @(posedge CLK);
    dr(8'h96, 1'b0, b); chk(b, 8'h03);
    $display("reset values done");
    for (i = 0; i < 6; i++)
    begin
      lf = lfsr(lf); d = 8'h00 | {3'b101, lf[4:0]};
      dw(d, lf[15:8], 1'b1);
      dw(d, ~lf[15:8], 1'b0);
      dr(d, 1'b0, b); chk(b, 8'h00);
      dr(d, 1'b1, b); chk(b, lf[15:8]);
    end
    $display("address modes done");
    lf = lfsr(lf); d = lf[7:0];
    xw(16'h0010, d); xw(16'h0020, ~d);
    PTR0 <= 16'h0020; PTR1 <= 16'h0010;
    dw(8'h96, 8'h04, 1'b0);
    #1 chk({7'h0, PTR_SEL}, 8'h01);
    X_USE_PTR <= 1'b1;
    xr(16'h0000, b); chk(b, d);
    dw(8'h96, 8'h00, 1'b0);
    xr(16'h0000, b); chk(b, ~d);
    X_USE_PTR <= 1'b0;
    $display("off-chip and pointers done");
    dw(8'h9D, 8'h03, 1'b0);
    dw(8'h96, 8'h18, 1'b0);
    lf = lfsr(lf); d = lf[7:0];
    xw(16'h07FF, d);
    dr(8'h96, 1'b0, b); chk(b, 8'h19);
    xr(16'h07FF, b); chk(b, d ^ 8'h80);
    wait_rdy();
    xr(16'h07FF, b); chk(b, d);
    dr(8'h9C, 1'b0, b); chk(b, 8'h01);
    chk({7'h0, IRQ}, 8'h01);
    dw(8'h9C, 8'h01, 1'b0);
    $display("byte write done");
    dw(8'h96, 8'h08, 1'b0);
    xw(16'h07FF, ~d);
    dr(8'h96, 1'b0, b); chk(b, 8'h0B);
    xr(16'h07FF, b); chk(b, d);
    dr(8'h9C, 1'b0, b); chk(b, 8'h02);
    chk({7'h0, IRQ}, 8'h01);
    dw(8'h9C, 8'h02, 1'b0);
    dr(8'h9C, 1'b0, b); chk(b, 8'h00);
    chk({7'h0, IRQ}, 8'h00);
    $display("refused write done");
    dw(8'h96, 8'h38, 1'b0);
    for (i = 0; i < 32; i++)
    begin
      lf = lfsr(lf); q[i] = lf[7:0];
      if (i == 31) dw(8'h96, 8'h18, 1'b0);
      xw(16'h0060 + 16'(i), q[i]);
      if (i == 30) dr(8'h96, 1'b0, b);
      if (i == 30) chk(b, 8'h3B);
    end
    dr(8'h96, 1'b0, b); chk(b, 8'h19);
    wait_rdy();
    for (i = 0; i < 32; i++)
    begin
      xr(16'h0060 + 16'(i), b); chk(b, q[i]);
    end
    dw(8'h96, 8'h00, 1'b0);
    $display("page write done");
    // Write while frozen must be lost
    CE <= 1'b0;
    dw(8'h96, 8'h04, 1'b0);
    CE <= 1'b1;
    dr(8'h96, 1'b0, b); chk(b, 8'h03);
    $display("clock enable done");
    report_and_stop();
  end
endmodule
